// File: rsw_pkg.sv
// Constants shared by the reset supervisor and watchdog files
`default_nettype none
package rsw_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam int SFR_AW = 8;
  localparam int SFR_DW = 8;
  localparam logic [7:0] SFR_POWER_CTRL = 8'h87;
  localparam logic [7:0] SFR_WDT_CLEAR = 8'ha6;
  localparam logic [7:0] SFR_WDT_KEY = 8'hae;
  localparam int LVR_DIS_BIT = 5;
  localparam logic LVR_DIS_RST = 1'b0;
  localparam logic [7:0] WDT_KEY_RST = 8'h00;
  localparam logic [7:0] WDT_KEY_DISABLE = 8'h55;
  localparam logic [7:0] WDT_PRELOAD_MAX = 8'h7e;
  // ****************************************
  // Watchdog counter
  // ****************************************
  localparam int WDT_W = 22;
  localparam int WDT_PRE_W = 7;
  localparam int WDT_LOW_W = 15;
  localparam logic [21:0] WDT_MAX = 22'h3fffff;
  // ****************************************
  // Timing
  // ****************************************
  localparam int MC_DIV = 12;
  localparam logic [3:0] MC_DIV_LAST = 4'hb;
  localparam int CLK_FREQ_HZ = 200_000_000;
  localparam int LVR_HOLD_MS = 10;
  localparam int LVR_HOLD_CYC = (CLK_FREQ_HZ / 1000) * LVR_HOLD_MS;
  localparam int LVR_CNT_W = 21;
  localparam int WDT_PULSE_OSC = 12 * (2 ** 15);
  localparam int WDT_PULSE_MC = WDT_PULSE_OSC / MC_DIV;
  localparam int WDT_PULSE_W = 16;
  // ****************************************
  // USB bus-reset detection
  // ****************************************
  localparam int USB_CNT_W = 4;
  localparam logic [3:0] USB_SE0_MIN = 4'h4;
  localparam logic [3:0] USB_SE0_MAX = 4'h8;
endpackage : rsw_pkg
`default_nettype wire

// File: rsw_core_if.sv
// Carrier between the supervisor top and its watchdog and USB detector
`default_nettype none
interface rsw_core_if;
  logic mc_en;
  logic hold;
  logic wdt_en;
  logic load;
  logic [6:0] load_val;
  logic ovf;
  logic [21:0] cnt;
  logic se0;
  logic usb_det;
  modport top (
    output mc_en, hold, wdt_en, load, load_val, se0,
    input ovf, cnt, usb_det
  );
  modport wdt (
    input mc_en, hold, wdt_en, load, load_val,
    output ovf, cnt
  );
  modport usb (
    input mc_en, se0,
    output usb_det
  );
endinterface : rsw_core_if
`default_nettype wire

// File: rsw_watchdog.sv
// Watchdog counter with preload, key enable and overflow pulse
`default_nettype none
module rsw_watchdog (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  rsw_core_if.wdt core
);
  import rsw_pkg::*;

  logic [WDT_W-1:0] cnt_nxt;
  logic ovf_nxt;
  logic step_w;

  // ****************************************
  // Counter
  // ****************************************
  // No idle gating: only power-down stops the machine cycle
  assign step_w = core.mc_en && core.wdt_en; // [R10] [R16] [R17]
  assign ovf_nxt = !core.hold && !core.load && step_w &&
                   (core.cnt == WDT_MAX); // [R12]
  always_comb begin
    cnt_nxt = core.cnt;
    if (core.hold) begin
      cnt_nxt = '0; // [R13]
    end else if (core.load) begin
      cnt_nxt = {core.load_val, {WDT_LOW_W{1'b0}}}; // [R14]
    end else if (step_w) begin
      cnt_nxt = core.cnt + 22'h000001; // [R10]
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      core.cnt <= '0;
      core.ovf <= 1'b0;
    end else begin
      core.cnt <= cnt_nxt;
      core.ovf <= ovf_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_wdt_inc;
    @(posedge mclk_in) disable iff (sys_rst_in)
    step_w && !core.hold && !core.load && core.cnt != WDT_MAX |=>
      core.cnt == $past(core.cnt) + 22'h000001;
  endproperty
  a_wdt_inc: assert property (p_wdt_inc) // [R10]
    else $error("watchdog did not count");
  property p_wdt_ovf;
    @(posedge mclk_in) disable iff (sys_rst_in)
    step_w && !core.hold && !core.load && core.cnt == WDT_MAX |=>
      core.ovf && core.cnt == '0;
  endproperty
  a_wdt_ovf: assert property (p_wdt_ovf) // [R12]
    else $error("watchdog overflow missed");
  property p_wdt_load;
    @(posedge mclk_in) disable iff (sys_rst_in)
    core.load && !core.hold |=>
      core.cnt == {$past(core.load_val), 15'h0000} && !core.ovf;
  endproperty
  a_wdt_load: assert property (p_wdt_load) // [R14]
    else $error("preload not applied");
  property p_wdt_key;
    @(posedge mclk_in) disable iff (sys_rst_in)
    !core.wdt_en && !core.load && !core.hold |=>
      $stable(core.cnt) && !core.ovf;
  endproperty
  a_wdt_key: assert property (p_wdt_key) // [R16]
    else $error("disabled watchdog moved");
  property p_wdt_hold;
    @(posedge mclk_in) disable iff (sys_rst_in)
    core.hold |=> core.cnt == '0 && !core.ovf;
  endproperty
  a_wdt_hold: assert property (p_wdt_hold) // [R13]
    else $error("counter not cleared by reset");
endmodule : rsw_watchdog
`default_nettype wire

// File: rsw_usb_det.sv
// Single-ended-zero run counter for USB bus-reset detection
`default_nettype none
module rsw_usb_det (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  rsw_core_if.usb core
);
  import rsw_pkg::*;

  logic [USB_CNT_W-1:0] run_r;
  logic [USB_CNT_W-1:0] run_nxt;
  logic det_nxt;

  // Saturating at the upper bound keeps one long SE0 from wrapping
  assign run_nxt = !core.mc_en ? run_r :
                   !core.se0 ? '0 :
                   (run_r == USB_SE0_MAX) ? run_r :
                   run_r + 4'h1;
  assign det_nxt = (run_nxt >= USB_SE0_MIN); // [R8]

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      run_r <= '0;
      core.usb_det <= 1'b0;
    end else begin
      run_r <= run_nxt;
      core.usb_det <= det_nxt;
    end
  end

  property p_usb_det;
    @(posedge mclk_in) disable iff (sys_rst_in)
    core.mc_en && core.se0 && run_r == 4'h3 |=> core.usb_det;
  endproperty
  a_usb_det: assert property (p_usb_det) // [R8]
    else $error("SE0 run not detected");
endmodule : rsw_usb_det
`default_nettype wire

// File: rsw_top.sv
// Reset supervisor: source merge, undervoltage hold, watchdog registers
// Contract
// R1: Any reset source asserts internal reset
// R2: Internal reset drives logic module, active low
// R3: Pin held low 1 ms at power-up
// R4: Undervoltage reset held 10 ms after recovery
// R5: Undervoltage reset enabled by default, software-disableable
// R6: Power control bit 5 disables undervoltage reset
// R7: Undervoltage reset works in idle and power-down
// R8: SE0 four to eight times sets flag
// R9: Enabled USB bus reset asserts internal reset
// R10: 22-bit counter increments each enabled machine cycle
// R11: Machine cycle is twelve clock periods
// R12: Counter overflow past all-ones causes reset
// R13: Watchdog enabled after power-up and reset
// R14: Preload 00h-7Eh loads top seven bits
// R15: Software reloads watchdog before overflow
// R16: Only key 55h disables the watchdog
// R17: Watchdog keeps counting and resetting in idle
// R18: Watchdog reset pulse lasts 32768 machine cycles
// R19: Idle software wakes periodically to service watchdog
// R20: Reset held until every source deasserts
// R21: Out-of-range preload ignored, bit 7 reads zero
`default_nettype none
module rsw_top #(
  parameter int unsigned LVR_HOLD_CYC = rsw_pkg::LVR_HOLD_CYC,
  parameter int unsigned WDT_PULSE_MC = rsw_pkg::WDT_PULSE_MC
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic ext_rst_n_in,
  input wire logic lvd_below_in,
  input wire logic power_down_in,
  input wire logic usb_se0_in,
  input wire logic usb_bus_reset_enable_in,
  input wire logic usb_flag_clr_in,
  input wire logic [rsw_pkg::SFR_AW-1:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [rsw_pkg::SFR_DW-1:0] sfr_wdata_in,
  output logic [rsw_pkg::SFR_DW-1:0] sfr_rdata_out,
  output logic sfr_hit_out,
  output logic int_rst_out,
  output logic plm_reset_n_out,
  output logic usb_bus_reset_flag_out,
  output logic undervolt_reset_disable_out
);
  import rsw_pkg::*;

  rsw_core_if core ();

  // ****************************************
  // Machine-cycle divider
  // ****************************************
  logic [3:0] div_r;
  logic [3:0] div_nxt;
  logic mc_en_r;
  logic mc_en_nxt;

  // Oscillator stops in power-down, so the machine cycle stops too
  assign div_nxt = power_down_in ? div_r :
                   (div_r == MC_DIV_LAST) ? 4'h0 :
                   div_r + 4'h1; // [R11]
  assign mc_en_nxt = !power_down_in && (div_r == MC_DIV_LAST); // [R11]

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      div_r <= 4'h0;
      mc_en_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      mc_en_r <= mc_en_nxt;
    end
  end

  // ****************************************
  // Register decode
  // ****************************************
  logic int_rst_r;
  logic [7:0] key_r;
  logic [7:0] key_nxt;
  logic lvr_dis_r;
  logic lvr_dis_nxt;
  logic wr_pre_w;
  logic pre_ok_w;
  logic wr_key_w;
  logic wr_power_control_register_w;
  logic hit_pre_w;
  logic hit_key_w;
  logic hit_power_control_register_w;

  assign hit_pre_w = (sfr_addr_in == SFR_WDT_CLEAR);
  assign hit_key_w = (sfr_addr_in == SFR_WDT_KEY);
  assign hit_power_control_register_w = (sfr_addr_in == SFR_POWER_CTRL);
  assign wr_pre_w = sfr_wr_in && hit_pre_w;
  assign wr_key_w = sfr_wr_in && hit_key_w;
  assign wr_power_control_register_w = sfr_wr_in && hit_power_control_register_w;
  assign pre_ok_w = (sfr_wdata_in <= WDT_PRELOAD_MAX); // [R21]

  // Internal reset wins over a write in the same cycle
  assign key_nxt = int_rst_r ? WDT_KEY_RST :
                   wr_key_w ? sfr_wdata_in : key_r; // [R13]
  // Only bit 5 of the shared power control word lives here
  assign lvr_dis_nxt = int_rst_r ? LVR_DIS_RST :
                       wr_power_control_register_w ? sfr_wdata_in[LVR_DIS_BIT] :
                       lvr_dis_r; // [R5] [R6]

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      key_r <= WDT_KEY_RST;
      lvr_dis_r <= LVR_DIS_RST;
    end else begin
      key_r <= key_nxt;
      lvr_dis_r <= lvr_dis_nxt;
    end
  end

  // ****************************************
  // Watchdog and USB detector
  // ****************************************
  assign core.mc_en = mc_en_r;
  assign core.hold = int_rst_r; // [R1]
  assign core.wdt_en = (key_r != WDT_KEY_DISABLE); // [R16]
  assign core.load = wr_pre_w && pre_ok_w; // [R14] [R21]
  assign core.load_val = sfr_wdata_in[WDT_PRE_W-1:0];
  assign core.se0 = usb_se0_in;

  rsw_watchdog u_wdt (
    .mclk_in (mclk_in),
    .sys_rst_in (sys_rst_in),
    .core (core.wdt)
  );

  rsw_usb_det u_usb (
    .mclk_in (mclk_in),
    .sys_rst_in (sys_rst_in),
    .core (core.usb)
  );

  // ****************************************
  // Read path
  // ****************************************
  logic [7:0] rd_val;
  logic rd_hit;
  logic [7:0] rdata_r;

  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b0;
    if (hit_pre_w) begin
      rd_val = {1'b0, core.cnt[WDT_W-1 -: WDT_PRE_W]}; // [R21]
      rd_hit = 1'b1;
    end else if (hit_key_w) begin
      rd_val = key_r;
      rd_hit = 1'b1;
    end else if (hit_power_control_register_w) begin
      rd_val[LVR_DIS_BIT] = lvr_dis_r;
      rd_hit = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rdata_r <= 8'h00;
    end else if (sfr_rd_in) begin
      rdata_r <= rd_val;
    end
  end

  assign sfr_rdata_out = rdata_r;
  assign sfr_hit_out = sfr_rd_in && rd_hit;

  // ****************************************
  // Undervoltage hold
  // ****************************************
  logic lvr_req_w;
  logic lvr_act_w;
  logic [LVR_CNT_W-1:0] lvr_cnt_r;
  logic [LVR_CNT_W-1:0] lvr_cnt_nxt;

  // Runs on the raw clock: no idle or power-down gating here
  assign lvr_req_w = lvd_below_in && !lvr_dis_r; // [R6] [R7]
  assign lvr_cnt_nxt = lvr_req_w ? LVR_CNT_W'(LVR_HOLD_CYC) :
                       (lvr_cnt_r != '0) ?
                       lvr_cnt_r - LVR_CNT_W'(1) :
                       lvr_cnt_r; // [R4]
  assign lvr_act_w = lvr_req_w || (lvr_cnt_r != '0); // [R4]

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      lvr_cnt_r <= '0;
    end else begin
      lvr_cnt_r <= lvr_cnt_nxt;
    end
  end

  // ****************************************
  // Watchdog reset pulse
  // ****************************************
  logic [WDT_PULSE_W-1:0] pulse_r;
  logic [WDT_PULSE_W-1:0] pulse_nxt;
  logic wdt_act_w;

  // Not cleared by internal reset, or the pulse would cut itself off
  assign pulse_nxt = core.ovf ? WDT_PULSE_W'(WDT_PULSE_MC) :
                     (mc_en_r && pulse_r != '0) ?
                     pulse_r - WDT_PULSE_W'(1) :
                     pulse_r; // [R18]
  assign wdt_act_w = (pulse_r != '0); // [R12]

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pulse_r <= '0;
    end else begin
      pulse_r <= pulse_nxt;
    end
  end

  // ****************************************
  // Reset merge and USB flag
  // ****************************************
  logic usb_req_w;
  logic src_any_w;
  logic usb_flag_r;
  logic usb_flag_nxt;

  assign usb_req_w = core.usb_det && usb_bus_reset_enable_in; // [R9]
  // Pin timing at power-up is the board's job; sampled as a level
  assign src_any_w = !ext_rst_n_in || lvr_act_w || usb_req_w ||
                     wdt_act_w; // [R1] [R20] [R3]
  // Detection beats a clear in the same cycle
  assign usb_flag_nxt = core.usb_det ||
                        (usb_flag_r && !usb_flag_clr_in); // [R8]

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      int_rst_r <= 1'b1;
      usb_flag_r <= 1'b0;
    end else begin
      int_rst_r <= src_any_w; // [R20]
      usb_flag_r <= usb_flag_nxt;
    end
  end

  assign int_rst_out = int_rst_r;
  assign plm_reset_n_out = !int_rst_r; // [R2]
  assign usb_bus_reset_flag_out = usb_flag_r;
  assign undervolt_reset_disable_out = lvr_dis_r;

  // ****************************************
  // Checks
  // ****************************************
  property p_src_rst;
    @(posedge mclk_in) disable iff (sys_rst_in)
    src_any_w |=> int_rst_out && !plm_reset_n_out;
  endproperty
  a_src_rst: assert property (p_src_rst) // [R1]
    else $error("reset source ignored");
  property p_hold_any;
    @(posedge mclk_in) disable iff (sys_rst_in)
    !ext_rst_n_in [*2] |-> int_rst_out [*2];
  endproperty
  a_hold_any: assert property (p_hold_any) // [R20]
    else $error("reset released while pin low");
  property p_plm_pol;
    @(posedge mclk_in) disable iff (sys_rst_in)
    $rose(int_rst_out) |-> $fell(plm_reset_n_out);
  endproperty
  a_plm_pol: assert property (p_plm_pol) // [R2]
    else $error("logic module reset polarity wrong");
  property p_lvr_hold;
    @(posedge mclk_in) disable iff (sys_rst_in)
    $fell(lvr_req_w) |-> lvr_cnt_r == LVR_CNT_W'(LVR_HOLD_CYC)
      ##1 int_rst_out [*8];
  endproperty
  a_lvr_hold: assert property (p_lvr_hold) // [R4]
    else $error("undervoltage hold too short");
  property p_lvr_dis;
    @(posedge mclk_in) disable iff (sys_rst_in)
    wr_power_control_register_w && !int_rst_r |=>
      lvr_dis_r == $past(sfr_wdata_in[LVR_DIS_BIT]) &&
      (lvr_req_w == (lvd_below_in && !lvr_dis_r));
  endproperty
  a_lvr_dis: assert property (p_lvr_dis) // [R6]
    else $error("undervoltage disable bit wrong");
  property p_lvr_dflt;
    @(posedge mclk_in) disable iff (sys_rst_in)
    int_rst_out |=> !lvr_dis_r;
  endproperty
  a_lvr_dflt: assert property (p_lvr_dflt) // [R5]
    else $error("undervoltage reset not enabled");
  property p_lvr_pd;
    @(posedge mclk_in) disable iff (sys_rst_in)
    power_down_in && lvr_req_w |=> int_rst_out;
  endproperty
  a_lvr_pd: assert property (p_lvr_pd) // [R7]
    else $error("undervoltage reset lost in power-down");
  property p_usb_rst;
    @(posedge mclk_in) disable iff (sys_rst_in)
    core.usb_det && usb_bus_reset_enable_in |=>
      int_rst_out && usb_bus_reset_flag_out;
  endproperty
  a_usb_rst: assert property (p_usb_rst) // [R9]
    else $error("USB bus reset not applied");
  property p_usb_flag;
    @(posedge mclk_in) disable iff (sys_rst_in)
    core.usb_det |=> usb_bus_reset_flag_out;
  endproperty
  a_usb_flag: assert property (p_usb_flag) // [R8]
    else $error("USB bus-reset flag lost");
  property p_mc_div;
    @(posedge mclk_in) disable iff (sys_rst_in)
    mc_en_r |=> !mc_en_r [*8];
  endproperty
  a_mc_div: assert property (p_mc_div) // [R11]
    else $error("machine cycle too short");
  property p_wdt_pulse;
    @(posedge mclk_in) disable iff (sys_rst_in)
    core.ovf |=> pulse_r == WDT_PULSE_W'(WDT_PULSE_MC)
      ##1 int_rst_out [*8];
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse) // [R18]
    else $error("watchdog pulse wrong");
  property p_pre_bad;
    @(posedge mclk_in) disable iff (sys_rst_in)
    wr_pre_w && !pre_ok_w && !mc_en_r && !int_rst_r |=>
      $stable(core.cnt);
  endproperty
  a_pre_bad: assert property (p_pre_bad) // [R21]
    else $error("out-of-range preload accepted");
  property p_pre_rd;
    @(posedge mclk_in) disable iff (sys_rst_in)
    sfr_rd_in && hit_pre_w |=> !sfr_rdata_out[7];
  endproperty
  a_pre_rd: assert property (p_pre_rd) // [R21]
    else $error("reserved bit read as one");
  property p_key_rst;
    @(posedge mclk_in) disable iff (sys_rst_in)
    int_rst_out |=> key_r == WDT_KEY_RST && core.wdt_en;
  endproperty
  a_key_rst: assert property (p_key_rst) // [R13]
    else $error("watchdog not enabled by reset");
endmodule : rsw_top
`default_nettype wire

// File: rsw_cpu_model.sv
// Far-side model: CPU register accesses and the reset sources
`default_nettype none
module rsw_cpu_model import rsw_pkg::*; (
  input wire logic mclk_in,
  input wire logic [rsw_pkg::SFR_DW-1:0] sfr_rdata_in,
  input wire logic sfr_hit_in,
  output logic ext_rst_n_out,
  output logic lvd_below_out,
  output logic power_down_out,
  output logic usb_se0_out,
  output logic usb_en_out,
  output logic usb_clr_out,
  output logic [rsw_pkg::SFR_AW-1:0] sfr_addr_out,
  output logic sfr_wr_out,
  output logic sfr_rd_out,
  output logic [rsw_pkg::SFR_DW-1:0] sfr_wdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Power-up sources
  // ****************************************
  initial begin
    ext_rst_n_out = 1'b0;
    lvd_below_out = 1'b0;
    power_down_out = 1'b0;
    usb_se0_out = 1'b0;
    usb_en_out = 1'b0;
    usb_clr_out = 1'b0;
    sfr_addr_out = 8'h00;
    sfr_wr_out = 1'b0;
    sfr_rd_out = 1'b0;
    sfr_wdata_out = 8'h00;
    // Pin low while clock runs; far shorter than real life to save time
    repeat (16) @(posedge mclk_in);
    ext_rst_n_out <= 1'b1;
  end
  // ****************************************
  // Register accesses
  // ****************************************
  // Service writes keep the counter clear of overflow
  // No idle here; an idling CPU would wake on a timer to service
  task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge mclk_in);
    sfr_addr_out <= addr;
    sfr_wdata_out <= data;
    sfr_wr_out <= 1'b1;
    @(posedge mclk_in);
    sfr_wr_out <= 1'b0;
    // Released bus shows garbage, not the old value
    sfr_addr_out <= ~addr;
    sfr_wdata_out <= ~data;
  endtask : sfr_write
  task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data,
                          output logic hit);
    @(posedge mclk_in);
    sfr_addr_out <= addr;
    sfr_rd_out <= 1'b1;
    #1;
    hit = sfr_hit_in;
    @(posedge mclk_in);
    sfr_rd_out <= 1'b0;
    sfr_addr_out <= ~addr;
    #1;
    data = sfr_rdata_in;
  endtask : sfr_read
endmodule : rsw_cpu_model
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the reset supervisor and watchdog
`default_nettype none
module testbench import rsw_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned HOLD = 20;
  localparam int unsigned PULSE = 16;
  localparam int TIMEOUT = 20000;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] exp;
    logic hit;
  } rsw_row_s;
  logic mclk_in;
  logic sys_rst_in;
  logic ext_rst_n, lvd_below, power_down, usb_se0, usb_en, usb_clr;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd_data;
  logic sfr_wr, sfr_rd, sfr_hit, rd_hit;
  logic int_rst, plm_rst_n, usb_flag, lvr_dis;
  logic [21:0] cnt_seen;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int n;
  rsw_row_s rows [11] = '{
    '{1'b1, 8'h87, 8'hff, 8'h20, 1'b1}, '{1'b1, 8'h87, 8'h00, 8'h00, 1'b1},
    '{1'b1, 8'hae, 8'h54, 8'h54, 1'b1}, '{1'b1, 8'hae, 8'h00, 8'h00, 1'b1},
    '{1'b1, 8'ha6, 8'h7e, 8'h7e, 1'b1}, '{1'b1, 8'ha6, 8'h7f, 8'h7e, 1'b1},
    '{1'b1, 8'ha6, 8'hff, 8'h7e, 1'b1}, '{1'b1, 8'ha6, 8'h05, 8'h05, 1'b1},
    '{1'b1, 8'ha6, 8'h00, 8'h00, 1'b1}, '{1'b0, 8'h90, 8'h00, 8'h00, 1'b0},
    '{1'b1, 8'h90, 8'hff, 8'h00, 1'b0}};

  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  rsw_cpu_model u_cpu (.mclk_in(mclk_in), .sfr_rdata_in(sfr_rdata),
    .sfr_hit_in(sfr_hit), .ext_rst_n_out(ext_rst_n),
    .lvd_below_out(lvd_below), .power_down_out(power_down),
    .usb_se0_out(usb_se0), .usb_en_out(usb_en), .usb_clr_out(usb_clr),
    .sfr_addr_out(sfr_addr), .sfr_wr_out(sfr_wr), .sfr_rd_out(sfr_rd),
    .sfr_wdata_out(sfr_wdata));

  rsw_top #(.LVR_HOLD_CYC(HOLD), .WDT_PULSE_MC(PULSE)) dut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .ext_rst_n_in(ext_rst_n),
    .lvd_below_in(lvd_below), .power_down_in(power_down),
    .usb_se0_in(usb_se0), .usb_bus_reset_enable_in(usb_en),
    .usb_flag_clr_in(usb_clr), .sfr_addr_in(sfr_addr), .sfr_wr_in(sfr_wr),
    .sfr_rd_in(sfr_rd), .sfr_wdata_in(sfr_wdata), .sfr_rdata_out(sfr_rdata),
    .sfr_hit_out(sfr_hit), .int_rst_out(int_rst),
    .plm_reset_n_out(plm_rst_n), .usb_bus_reset_flag_out(usb_flag),
    .undervolt_reset_disable_out(lvr_dis));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    if (errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  // Edges until internal reset drops, bounded so a stuck reset ends it
  task automatic measure(output int cnt);
    cnt = 0;
    do begin
      @(posedge mclk_in);
      #1;
      cnt++;
    end while (int_rst === 1'b1 && cnt < 200);
  endtask : measure
  task automatic next_step(output logic [21:0] v);
    v = dut.u_wdt.core.cnt;
    for (int i = 0; i < 30 && dut.u_wdt.core.cnt === v; i++) begin
      @(posedge mclk_in);
      #1;
    end
    v = dut.u_wdt.core.cnt;
  endtask : next_step
  task automatic edges(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask : edges

  always @(posedge mclk_in) begin
    cycles++;
    if (cycles >= TIMEOUT) begin
      errors++;
      end_of_test();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    sys_rst_in = 1'b1;
    repeat (10) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    measure(n);
    check(plm_rst_n, 1'b1);
    check(lvr_dis, 1'b0);
    u_cpu.sfr_read(SFR_WDT_KEY, rd_data, rd_hit);
    check(rd_data, WDT_KEY_RST);
    for (int i = 0; i < 11; i++) begin
      if (rows[i].wr) u_cpu.sfr_write(rows[i].addr, rows[i].data);
      u_cpu.sfr_read(rows[i].addr, rd_data, rd_hit);
      check(rd_data, rows[i].exp);
      check(rd_hit, rows[i].hit);
    end
    // Preload lands exactly, then the counter steps once every twelve edges
    u_cpu.sfr_write(SFR_WDT_CLEAR, 8'h05);
    #1;
    check(dut.u_wdt.core.cnt, {7'h05, 15'h0000});
    next_step(cnt_seen);
    edges(11);
    check(dut.u_wdt.core.cnt, cnt_seen);
    edges(1);
    check(dut.u_wdt.core.cnt, cnt_seen + 22'h1);
    // Only the one key value stops counting
    u_cpu.sfr_write(SFR_WDT_KEY, WDT_KEY_DISABLE);
    #1;
    cnt_seen = dut.u_wdt.core.cnt;
    edges(36);
    check(dut.u_wdt.core.cnt, cnt_seen);
    u_cpu.sfr_write(SFR_WDT_KEY, 8'haa);
    edges(24);
    check(dut.u_wdt.core.cnt !== cnt_seen, 1'b1);
    // Disable bit masks the detector
    u_cpu.sfr_write(SFR_POWER_CTRL, 8'h20);
    #1;
    check(lvr_dis, 1'b1);
    u_cpu.sfr_write(SFR_WDT_KEY, WDT_KEY_DISABLE);
    u_cpu.lvd_below_out <= 1'b1;
    edges(6);
    check(int_rst, 1'b0);
    // Pin and detector overlap; reset outlives the detector hold
    u_cpu.ext_rst_n_out <= 1'b0;
    edges(3);
    check(int_rst, 1'b1);
    check(plm_rst_n, 1'b0);
    @(posedge mclk_in);
    u_cpu.lvd_below_out <= 1'b0;
    edges(40);
    check(int_rst, 1'b1);
    u_cpu.ext_rst_n_out <= 1'b1;
    measure(n);
    check(n <= 3, 1'b1);
    check(lvr_dis, 1'b0);
    u_cpu.sfr_read(SFR_WDT_KEY, rd_data, rd_hit);
    check(rd_data, WDT_KEY_RST);
    // Detector in power-down, then the hold after recovery
    @(posedge mclk_in);
    u_cpu.power_down_out <= 1'b1;
    u_cpu.lvd_below_out <= 1'b1;
    edges(3);
    check(int_rst, 1'b1);
    @(posedge mclk_in);
    u_cpu.lvd_below_out <= 1'b0;
    measure(n);
    check(n >= HOLD && n <= HOLD + 4, 1'b1);
    u_cpu.power_down_out <= 1'b0;
    // Three samples of SE0 fall short, five set the flag
    @(posedge mclk_in);
    u_cpu.usb_se0_out <= 1'b1;
    edges(36);
    u_cpu.usb_se0_out <= 1'b0;
    edges(3);
    check(usb_flag, 1'b0);
    u_cpu.usb_se0_out <= 1'b1;
    edges(60);
    u_cpu.usb_se0_out <= 1'b0;
    // Detector lets go only on the next machine cycle; clear after it
    edges(13);
    check(usb_flag, 1'b1);
    check(int_rst, 1'b0);
    u_cpu.usb_clr_out <= 1'b1;
    edges(1);
    u_cpu.usb_clr_out <= 1'b0;
    edges(2);
    check(usb_flag, 1'b0);
    u_cpu.usb_en_out <= 1'b1;
    u_cpu.usb_se0_out <= 1'b1;
    edges(60);
    check(int_rst, 1'b1);
    @(posedge mclk_in);
    u_cpu.usb_se0_out <= 1'b0;
    measure(n);
    check(n <= 16, 1'b1);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
